// [logic/io_register_space_decode.sv]
// Decoder and storage of the 64-byte I/O register space of the core
`timescale 1ns/1ns
`include "io_space_defs.svh"

module io_register_space_decode (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Core access
    input wire io_space_pkg::core_req_s i_req,
    // Peripheral side
    input wire io_space_pkg::pin_level_s i_pins,
    input wire io_space_pkg::flag_set_s i_flag_set,
    // Answers
    output logic [7:0] o_rdata,
    output logic o_skip,
    output logic o_done,
    output io_space_pkg::reg_bank_t o_bank
);

    io_space_pkg::space_state_s state_r;
    io_space_pkg::space_state_s state_nxt;

    // Bits that exist in each register; everything else is reserved
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `IO_RESET_VALUE;
        case (a)
            `A_DIGITAL_INPUT_DISABLE: begin
                m = 8'h03;
            end
            `A_BAUD_DIVISOR_HIGH: begin
                m = 8'h0F;
            end
            `A_SERIAL_FRAME_FORMAT: begin
                m = 8'h7F;
            end
            `A_COMPARATOR_CONTROL_STATUS: begin
                m = 8'hFF;
            end
            `A_BAUD_DIVISOR_LOW: begin
                m = 8'hFF;
            end
            `A_SERIAL_CONTROL_B: begin
                m = 8'hFF;
            end
            `A_SERIAL_STATUS_A: begin
                m = 8'hFF;
            end
            `A_SERIAL_DATA_BUFFER: begin
                m = 8'hFF;
            end
            `A_UNIVERSAL_SERIAL_CONTROL: begin
                m = 8'hFF;
            end
            `A_UNIVERSAL_SERIAL_STATUS: begin
                m = 8'hFF;
            end
            `A_UNIVERSAL_SERIAL_DATA: begin
                m = 8'hFF;
            end
            `A_PORT_D_INPUT_LEVEL: begin
                m = 8'h7F;
            end
            `A_PORT_D_DIRECTION: begin
                m = 8'h7F;
            end
            `A_PORT_D_OUTPUT: begin
                m = 8'h7F;
            end
            `A_SCRATCH_BYTE_0: begin
                m = 8'hFF;
            end
            `A_SCRATCH_BYTE_1: begin
                m = 8'hFF;
            end
            `A_SCRATCH_BYTE_2: begin
                m = 8'hFF;
            end
            `A_PORT_B_INPUT_LEVEL: begin
                m = 8'hFF;
            end
            `A_PORT_B_DIRECTION: begin
                m = 8'hFF;
            end
            `A_PORT_B_OUTPUT: begin
                m = 8'hFF;
            end
            `A_PORT_A_INPUT_LEVEL: begin
                m = 8'h07;
            end
            `A_PORT_A_DIRECTION: begin
                m = 8'h07;
            end
            `A_PORT_A_OUTPUT: begin
                m = 8'h07;
            end
            `A_EEPROM_CONTROL: begin
                m = 8'h3F;
            end
            `A_EEPROM_DATA: begin
                m = 8'hFF;
            end
            `A_EEPROM_ADDRESS: begin
                m = 8'h7F;
            end
            `A_PIN_CHANGE_MASK: begin
                m = 8'hFF;
            end
            `A_WATCHDOG_CONTROL: begin
                m = 8'hFF;
            end
            `A_TIMER1_FORCE_COMPARE: begin
                m = 8'hC0;
            end
            `A_PRESCALER_RESET_CONTROL: begin
                m = 8'h01;
            end
            `A_TIMER1_CAPTURE_LOW: begin
                m = 8'hFF;
            end
            `A_TIMER1_CAPTURE_HIGH: begin
                m = 8'hFF;
            end
            `A_CLOCK_DIVIDER: begin
                m = 8'h8F;
            end
            `A_TIMER1_COMPARE_B_LOW: begin
                m = 8'hFF;
            end
            `A_TIMER1_COMPARE_B_HIGH: begin
                m = 8'hFF;
            end
            `A_TIMER1_COMPARE_A_LOW: begin
                m = 8'hFF;
            end
            `A_TIMER1_COMPARE_A_HIGH: begin
                m = 8'hFF;
            end
            `A_TIMER1_COUNT_LOW: begin
                m = 8'hFF;
            end
            `A_TIMER1_COUNT_HIGH: begin
                m = 8'hFF;
            end
            `A_TIMER1_CONTROL_B: begin
                m = 8'hDF;
            end
            `A_TIMER1_CONTROL_A: begin
                m = 8'hF3;
            end
            `A_TIMER0_CONTROL_A: begin
                m = 8'hF3;
            end
            `A_OSCILLATOR_TRIM: begin
                m = 8'h7F;
            end
            `A_TIMER0_COUNT: begin
                m = 8'hFF;
            end
            `A_TIMER0_CONTROL_B: begin
                m = 8'hCF;
            end
            `A_RESET_CAUSE_FLAGS: begin
                m = 8'h0F;
            end
            `A_SLEEP_AND_SENSE_CONTROL: begin
                m = 8'hFF;
            end
            `A_TIMER0_COMPARE_A: begin
                m = 8'hFF;
            end
            `A_SELF_PROGRAM_CONTROL: begin
                m = 8'h1F;
            end
            `A_TIMER_INT_FLAGS: begin
                m = 8'hDF;
            end
            `A_TIMER_INT_MASK: begin
                m = 8'hDF;
            end
            `A_EXT_INT_FLAGS: begin
                m = 8'hE0;
            end
            `A_EXT_INT_MASK: begin
                m = 8'hE0;
            end
            `A_TIMER0_COMPARE_B: begin
                m = 8'hFF;
            end
            `A_STACK_POINTER_LOW: begin
                m = 8'hFF;
            end
            `A_STATUS_FLAGS: begin
                m = 8'hFF;
            end
            default: begin
                m = `IO_RESET_VALUE;
            end
        endcase
        return m;
    endfunction

    // Status flags that a written one clears
    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `IO_RESET_VALUE;
        case (a)
            `A_COMPARATOR_CONTROL_STATUS: m = 8'h10;
            `A_SERIAL_STATUS_A: m = 8'h40;
            `A_UNIVERSAL_SERIAL_STATUS: m = 8'hE0;
            `A_WATCHDOG_CONTROL: m = 8'h80;
            `A_TIMER_INT_FLAGS: m = 8'hDF;
            `A_EXT_INT_FLAGS: m = 8'hE0;
            default: m = `IO_RESET_VALUE;
        endcase
        return m;
    endfunction

    // Pin level registers follow the pins, so the core cannot write them
    function automatic logic ro_reg(input logic [5:0] a);
        return (a == `A_PORT_A_INPUT_LEVEL) || (a == `A_PORT_B_INPUT_LEVEL)
            || (a == `A_PORT_D_INPUT_LEVEL);
    endfunction

    // Force-compare strobes are write only and always read back as zero
    function automatic logic [7:0] read_byte(input io_space_pkg::reg_bank_t b,
                                             input logic [5:0] a);
        logic [7:0] v;
        v = b[a] & impl_mask(a);
        if (a == `A_TIMER1_FORCE_COMPARE) begin
            v = `IO_RESET_VALUE;
        end
        return v;
    endfunction

    // Merge a write of value v over the bits selected by m
    function automatic logic [7:0] write_byte(input logic [7:0] old,
                                              input logic [7:0] v,
                                              input logic [7:0] m,
                                              input logic [5:0] a);
        logic [7:0] im;
        logic [7:0] fm;
        logic [7:0] rw;
        im = impl_mask(a) & m;
        fm = w1c_mask(a) & im;
        rw = im & ~fm;
        return (old & ~rw & ~(fm & v)) | (v & rw);
    endfunction

    logic [5:0] io_idx;
    logic in_space;
    logic [7:0] bit_m;

    always_comb begin
        io_idx = i_req.addr[5:0];
        in_space = 1'b0;
        case (i_req.op)
            io_space_pkg::io_in_op,
            io_space_pkg::io_out_op: begin
                in_space = (i_req.addr <= `IO_LAST_ADDR);
            end
            io_space_pkg::data_space_load_op,
            io_space_pkg::data_space_store_op: begin
                io_idx = 6'(i_req.addr - `IO_DATA_OFFSET);
                in_space = (i_req.addr >= `IO_DATA_OFFSET)
                    && (i_req.addr <= 8'(`IO_LAST_ADDR + `IO_DATA_OFFSET));
            end
            io_space_pkg::set_single_bit_op,
            io_space_pkg::clear_single_bit_op,
            io_space_pkg::skip_if_bit_high_op,
            io_space_pkg::skip_if_bit_low_op: begin
                in_space = (i_req.addr <= 8'(`IO_BIT_LAST));
            end
            default: begin
                in_space = 1'b0;
            end
        endcase
        bit_m = 8'h01 << i_req.bit_sel;
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        state_nxt.skip = 1'b0;
        // Pins are taken as synchronous and land one cycle later
        state_nxt.regs[`A_PORT_A_INPUT_LEVEL] = {5'h00, i_pins.port_a};
        state_nxt.regs[`A_PORT_B_INPUT_LEVEL] = i_pins.port_b;
        state_nxt.regs[`A_PORT_D_INPUT_LEVEL] = {1'b0, i_pins.port_d};
        if (i_req.op != io_space_pkg::no_op) begin
            state_nxt.done = 1'b1;
            state_nxt.rdata = `IO_RESET_VALUE;
        end
        if (in_space) begin
            case (i_req.op)
                io_space_pkg::io_in_op,
                io_space_pkg::data_space_load_op: begin
                    state_nxt.rdata = read_byte(state_r.regs, io_idx);
                end
                io_space_pkg::io_out_op,
                io_space_pkg::data_space_store_op: begin
                    if (!ro_reg(io_idx)) begin
                        state_nxt.regs[io_idx] = write_byte(state_r.regs[io_idx],
                            i_req.wdata, `IO_ALL_BITS, io_idx);
                    end
                end
                io_space_pkg::set_single_bit_op: begin
                    if (!ro_reg(io_idx)) begin
                        state_nxt.regs[io_idx] = write_byte(state_r.regs[io_idx],
                            `IO_ALL_BITS, bit_m, io_idx);
                    end
                end
                io_space_pkg::clear_single_bit_op: begin
                    if (!ro_reg(io_idx)) begin
                        state_nxt.regs[io_idx] = write_byte(state_r.regs[io_idx],
                            `IO_RESET_VALUE, bit_m, io_idx);
                    end
                end
                io_space_pkg::skip_if_bit_high_op: begin
                    state_nxt.skip = |(read_byte(state_r.regs, io_idx) & bit_m);
                end
                io_space_pkg::skip_if_bit_low_op: begin
                    state_nxt.skip = ~|(read_byte(state_r.regs, io_idx) & bit_m);
                end
                default: begin
                    state_nxt.skip = 1'b0;
                end
            endcase
        end
        // A flag event in the same cycle as its clear survives
        state_nxt.regs[`A_TIMER_INT_FLAGS] = state_nxt.regs[`A_TIMER_INT_FLAGS]
            | (i_flag_set.timer_flags & w1c_mask(`A_TIMER_INT_FLAGS));
        state_nxt.regs[`A_EXT_INT_FLAGS][7:5] = state_nxt.regs[`A_EXT_INT_FLAGS][7:5]
            | i_flag_set.ext_flags;
        state_nxt.regs[`A_UNIVERSAL_SERIAL_STATUS][7:5] =
            state_nxt.regs[`A_UNIVERSAL_SERIAL_STATUS][7:5] | i_flag_set.usi_flags;
        state_nxt.regs[`A_SERIAL_STATUS_A][6] = state_nxt.regs[`A_SERIAL_STATUS_A][6]
            | i_flag_set.tx_complete;
        state_nxt.regs[`A_COMPARATOR_CONTROL_STATUS][4] =
            state_nxt.regs[`A_COMPARATOR_CONTROL_STATUS][4] | i_flag_set.comparator_int;
        state_nxt.regs[`A_WATCHDOG_CONTROL][7] = state_nxt.regs[`A_WATCHDOG_CONTROL][7]
            | i_flag_set.watchdog_int;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_rdata = state_r.rdata;
    assign o_skip = state_r.skip;
    assign o_done = state_r.done;
    assign o_bank = state_r.regs;

endmodule

// [logic/io_space_defs.svh]
// Register offsets, data-space offset and reset value of the I/O register space
`ifndef IO_SPACE_DEFS_SVH
`define IO_SPACE_DEFS_SVH

`define IO_DATA_OFFSET 8'h20
`define IO_LAST_ADDR 8'h3F
`define IO_BIT_LAST 6'h1F
`define IO_RESET_VALUE 8'h00
`define IO_ALL_BITS 8'hFF

`define A_DIGITAL_INPUT_DISABLE 6'h01
`define A_BAUD_DIVISOR_HIGH 6'h02
`define A_SERIAL_FRAME_FORMAT 6'h03
`define A_COMPARATOR_CONTROL_STATUS 6'h08
`define A_BAUD_DIVISOR_LOW 6'h09
`define A_SERIAL_CONTROL_B 6'h0A
`define A_SERIAL_STATUS_A 6'h0B
`define A_SERIAL_DATA_BUFFER 6'h0C
`define A_UNIVERSAL_SERIAL_CONTROL 6'h0D
`define A_UNIVERSAL_SERIAL_STATUS 6'h0E
`define A_UNIVERSAL_SERIAL_DATA 6'h0F
`define A_PORT_D_INPUT_LEVEL 6'h10
`define A_PORT_D_DIRECTION 6'h11
`define A_PORT_D_OUTPUT 6'h12
`define A_SCRATCH_BYTE_0 6'h13
`define A_SCRATCH_BYTE_1 6'h14
`define A_SCRATCH_BYTE_2 6'h15
`define A_PORT_B_INPUT_LEVEL 6'h16
`define A_PORT_B_DIRECTION 6'h17
`define A_PORT_B_OUTPUT 6'h18
`define A_PORT_A_INPUT_LEVEL 6'h19
`define A_PORT_A_DIRECTION 6'h1A
`define A_PORT_A_OUTPUT 6'h1B
`define A_EEPROM_CONTROL 6'h1C
`define A_EEPROM_DATA 6'h1D
`define A_EEPROM_ADDRESS 6'h1E
`define A_PIN_CHANGE_MASK 6'h20
`define A_WATCHDOG_CONTROL 6'h21
`define A_TIMER1_FORCE_COMPARE 6'h22
`define A_PRESCALER_RESET_CONTROL 6'h23
`define A_TIMER1_CAPTURE_LOW 6'h24
`define A_TIMER1_CAPTURE_HIGH 6'h25
`define A_CLOCK_DIVIDER 6'h26
`define A_TIMER1_COMPARE_B_LOW 6'h28
`define A_TIMER1_COMPARE_B_HIGH 6'h29
`define A_TIMER1_COMPARE_A_LOW 6'h2A
`define A_TIMER1_COMPARE_A_HIGH 6'h2B
`define A_TIMER1_COUNT_LOW 6'h2C
`define A_TIMER1_COUNT_HIGH 6'h2D
`define A_TIMER1_CONTROL_B 6'h2E
`define A_TIMER1_CONTROL_A 6'h2F
`define A_TIMER0_CONTROL_A 6'h30
`define A_OSCILLATOR_TRIM 6'h31
`define A_TIMER0_COUNT 6'h32
`define A_TIMER0_CONTROL_B 6'h33
`define A_RESET_CAUSE_FLAGS 6'h34
`define A_SLEEP_AND_SENSE_CONTROL 6'h35
`define A_TIMER0_COMPARE_A 6'h36
`define A_SELF_PROGRAM_CONTROL 6'h37
`define A_TIMER_INT_FLAGS 6'h38
`define A_TIMER_INT_MASK 6'h39
`define A_EXT_INT_FLAGS 6'h3A
`define A_EXT_INT_MASK 6'h3B
`define A_TIMER0_COMPARE_B 6'h3C
`define A_STACK_POINTER_LOW 6'h3D
`define A_STATUS_FLAGS 6'h3F

`endif

// [logic/io_space_pkg.sv]
// Types shared by the I/O register space and its users
package io_space_pkg;

    typedef enum logic [3:0] {
        no_op,
        io_in_op,
        io_out_op,
        data_space_load_op,
        data_space_store_op,
        set_single_bit_op,
        clear_single_bit_op,
        skip_if_bit_high_op,
        skip_if_bit_low_op
    } core_op_e;

    typedef struct packed {
        core_op_e op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } core_req_s;

    typedef struct packed {
        logic [2:0] port_a;
        logic [7:0] port_b;
        logic [6:0] port_d;
    } pin_level_s;

    typedef struct packed {
        logic [7:0] timer_flags;
        logic [2:0] ext_flags;
        logic [2:0] usi_flags;
        logic tx_complete;
        logic comparator_int;
        logic watchdog_int;
    } flag_set_s;

    typedef logic [63:0][7:0] reg_bank_t;

    typedef struct packed {
        reg_bank_t regs;
        logic [7:0] rdata;
        logic skip;
        logic done;
    } space_state_s;

endpackage

// [testbench/core_model.sv]
// Core-side model issuing one register space operation per call
`timescale 1ns/1ns
module core_model (
    // Clock
    input wire logic i_core_clk,
    // Request
    output io_space_pkg::core_req_s o_req,
    // Answer
    input wire logic [7:0] i_rdata,
    input wire logic i_skip,
    input wire logic i_done
);
    initial begin
        o_req = '0;
    end
    // One op, driven at the next edge and taken at the edge after it
    task automatic xfer(input io_space_pkg::core_op_e op, input logic [7:0] addr,
        input logic [2:0] bsel, input logic [7:0] wd, output logic [7:0] rd,
        output logic sk, output logic dn);
        @(posedge i_core_clk);
        o_req <= '{op, addr, bsel, wd};
        @(posedge i_core_clk);
        o_req.op <= io_space_pkg::no_op;
        #1;
        rd = i_rdata;
        sk = i_skip;
        dn = i_done;
    endtask
endmodule

// [testbench/io_space_checker.sv]
// Port-level assertions for the I/O register space decoder
`timescale 1ns/1ns
module io_space_checker (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Inputs watched
    input wire io_space_pkg::core_req_s i_req,
    input wire io_space_pkg::pin_level_s i_pins,
    input wire io_space_pkg::flag_set_s i_flag_set,
    // Outputs watched
    input wire logic [7:0] o_rdata,
    input wire logic o_skip,
    input wire logic o_done,
    input wire io_space_pkg::reg_bank_t o_bank
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    wire io_space_pkg::core_op_e op = i_req.op;
    wire logic [5:0] a = i_req.addr[5:0];
    wire logic low = i_req.addr <= 8'h1F;
    wire logic bitop = op == io_space_pkg::set_single_bit_op
        || op == io_space_pkg::clear_single_bit_op;
    wire logic calm = i_flag_set == '0;
    done_follows_a: assert property (op != io_space_pkg::no_op |=> o_done)
        else $error("no done after an op");
    done_idle_a: assert property (op == io_space_pkg::no_op |=> !o_done)
        else $error("done without an op");
    skip_high_a: assert property (op == io_space_pkg::skip_if_bit_high_op && low
        |=> o_skip == $past(o_bank[a][i_req.bit_sel])) else $error("skip high wrong");
    skip_low_a: assert property (op == io_space_pkg::skip_if_bit_low_op && low
        |=> o_skip == !$past(o_bank[a][i_req.bit_sel])) else $error("skip low wrong");
    // Pins held steady so that only the op can touch the bank
    bit_others_a: assert property (bitop && low && calm && $stable(i_pins)
        && i_pins == $past(i_pins, 2)
        |=> (o_bank[$past(a)] | (8'h01 << $past(i_req.bit_sel)))
        == ($past(o_bank[a]) | (8'h01 << $past(i_req.bit_sel))))
        else $error("bit op touched other bits");
    upper_bit_a: assert property (bitop && i_req.addr[7:5] == 3'b001 && calm
        |=> o_bank[$past(a)] == $past(o_bank[a])) else $error("bit op above range");
    io_read_a: assert property (op == io_space_pkg::io_in_op && !i_req.addr[7:6]
        && a != 6'h22 |=> o_rdata == $past(o_bank[a])) else $error("io read wrong");
    refused_a: assert property (op == io_space_pkg::io_in_op && i_req.addr > 8'h3F
        |=> o_rdata == 8'h00) else $error("refused read not zero");
    data_read_a: assert property (op == io_space_pkg::data_space_load_op
        && i_req.addr inside {[8'h20:8'h5F]} && i_req.addr != 8'h42
        |=> o_rdata == $past(o_bank[a - 6'h20])) else $error("load read wrong");
    reset_clear_a: assert property ($rose(i_nrst) |-> o_bank == '0 && !o_done)
        else $error("state not cleared by reset");
endmodule

bind io_register_space_decode io_space_checker chk (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .i_req(i_req), .i_pins(i_pins), .i_flag_set(i_flag_set),
    .o_rdata(o_rdata), .o_skip(o_skip), .o_done(o_done), .o_bank(o_bank));

// [testbench/tb.sv]
// Self-checking bench of the I/O register space decoder
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
    localparam io_space_pkg::core_op_e op_in = io_space_pkg::io_in_op;
    localparam io_space_pkg::core_op_e op_out = io_space_pkg::io_out_op;
    localparam io_space_pkg::core_op_e op_ld = io_space_pkg::data_space_load_op;
    localparam io_space_pkg::core_op_e op_st = io_space_pkg::data_space_store_op;
    localparam io_space_pkg::core_op_e op_set = io_space_pkg::set_single_bit_op;
    localparam io_space_pkg::core_op_e op_clr = io_space_pkg::clear_single_bit_op;
    localparam io_space_pkg::core_op_e op_hi = io_space_pkg::skip_if_bit_high_op;
    localparam io_space_pkg::core_op_e op_lo = io_space_pkg::skip_if_bit_low_op;
    logic i_core_clk;
    logic i_nrst;
    io_space_pkg::core_req_s req;
    io_space_pkg::pin_level_s pins;
    io_space_pkg::flag_set_s flags;
    logic [7:0] rdata;
    logic skip;
    logic done;
    io_space_pkg::reg_bank_t bank;
    logic [7:0] rd;
    logic sk;
    logic dn;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    io_register_space_decode dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req(req),
        .i_pins(pins), .i_flag_set(flags), .o_rdata(rdata), .o_skip(skip), .o_done(done),
        .o_bank(bank));
    core_model core (.i_core_clk(i_core_clk), .o_req(req), .i_rdata(rdata), .i_skip(skip),
        .i_done(done));
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic op(input io_space_pkg::core_op_e o, input logic [7:0] a,
        input logic [2:0] b, input logic [7:0] w);
        core.xfer(o, a, b, w, rd, sk, dn);
        `CHK(dn, 1'b1)
    endtask
    // Plain byte writes read back through both I/O and data-space addresses
    task automatic t_byte();
        op(op_out, 8'h13, 3'h0, 8'h5A);
        op(op_in, 8'h13, 3'h0, 8'h00);
        `CHK(rd, 8'h5A)
        op(op_ld, 8'h33, 3'h0, 8'h00);
        `CHK(rd, 8'h5A)
        op(op_st, 8'h34, 3'h0, 8'hC6);
        op(op_in, 8'h14, 3'h0, 8'h00);
        `CHK(rd, 8'hC6)
        op(op_out, 8'h3F, 3'h0, 8'hA5);
        op(op_ld, 8'h5F, 3'h0, 8'h00);
        `CHK(rd, 8'hA5)
    endtask
    task automatic t_reserved();
        op(op_ld, 8'h5E, 3'h0, 8'h00);
        `CHK(rd, 8'h00)
        op(op_in, 8'h3E, 3'h0, 8'h00);
        `CHK(rd, 8'h00)
        op(op_out, 8'h11, 3'h0, 8'h7F);
        op(op_in, 8'h11, 3'h0, 8'h00);
        `CHK(rd, 8'h7F)
        op(op_lo, 8'h11, 3'h7, 8'h00);
        `CHK(sk, 1'b1)
        op(op_in, 8'h40, 3'h0, 8'h00);
        `CHK(rd, 8'h00)
        op(op_ld, 8'h1F, 3'h0, 8'h00);
        `CHK(rd, 8'h00)
    endtask
    task automatic t_bits();
        for (int b = 0; b < 8; b++) begin
            op(op_set, 8'h17, 3'(b), 8'h00);
            `CHK(bank[6'h17], 8'h01 << b)
            op(op_hi, 8'h17, 3'(b), 8'h00);
            `CHK(sk, 1'b1)
            op(op_clr, 8'h17, 3'(b), 8'h00);
            `CHK(bank[6'h17], 8'h00)
            op(op_lo, 8'h17, 3'(b), 8'h00);
            `CHK(sk, 1'b1)
            op(op_hi, 8'h17, 3'(b), 8'h00);
            `CHK(sk, 1'b0)
        end
        op(op_out, 8'h20, 3'h0, 8'h0F);
        op(op_set, 8'h20, 3'h7, 8'h00);
        op(op_clr, 8'h20, 3'h0, 8'h00);
        `CHK(bank[6'h20], 8'h0F)
        op(op_hi, 8'h20, 3'h0, 8'h00);
        `CHK(sk, 1'b0)
    endtask
    task automatic t_flags();
        @(posedge i_core_clk);
        flags.tx_complete <= 1'b1;
        flags.comparator_int <= 1'b1;
        @(posedge i_core_clk);
        flags <= '0;
        op(op_out, 8'h0B, 3'h0, 8'h00);
        `CHK(bank[6'h0B][6], 1'b1)
        op(op_set, 8'h08, 3'h0, 8'h00);
        `CHK(bank[6'h08], 8'h11)
        op(op_set, 8'h0B, 3'h6, 8'h00);
        `CHK(bank[6'h0B][6], 1'b0)
        op(op_clr, 8'h08, 3'h0, 8'h00);
        `CHK(bank[6'h08], 8'h10)
        op(op_out, 8'h08, 3'h0, 8'h10);
        `CHK(bank[6'h08], 8'h00)
        @(posedge i_core_clk);
        flags <= '{8'hFF, 3'h7, 3'h7, 1'b0, 1'b0, 1'b1};
        @(posedge i_core_clk);
        flags <= '0;
        op(op_in, 8'h38, 3'h0, 8'h00);
        `CHK(rd, 8'hDF)
        op(op_ld, 8'h5A, 3'h0, 8'h00);
        `CHK(rd, 8'hE0)
        `CHK(bank[6'h0E], 8'hE0)
        `CHK(bank[6'h21], 8'h80)
        op(op_out, 8'h38, 3'h0, 8'h21);
        `CHK(bank[6'h38], 8'hDE)
        // Flag event and its clear in one cycle: the event wins
        fork
            op(op_out, 8'h21, 3'h0, 8'h80);
            begin
                @(posedge i_core_clk);
                flags.watchdog_int <= 1'b1;
                @(posedge i_core_clk);
                flags <= '0;
            end
        join
        `CHK(bank[6'h21], 8'h80)
        op(op_out, 8'h21, 3'h0, 8'h80);
        `CHK(bank[6'h21], 8'h00)
    endtask
    task automatic t_pins();
        @(posedge i_core_clk);
        pins <= '{3'h5, 8'hC3, 7'h2A};
        repeat (4) @(posedge i_core_clk);
        op(op_in, 8'h16, 3'h0, 8'h00);
        `CHK(rd, 8'hC3)
        op(op_out, 8'h16, 3'h0, 8'h00);
        op(op_in, 8'h16, 3'h0, 8'h00);
        `CHK(rd, 8'hC3)
        op(op_hi, 8'h19, 3'h2, 8'h00);
        `CHK(sk, 1'b1)
        op(op_ld, 8'h30, 3'h0, 8'h00);
        `CHK(rd, 8'h2A)
    endtask
    task automatic t_mid_reset();
        @(posedge i_core_clk);
        i_nrst <= 1'b0;
        @(posedge i_core_clk);
        #1;
        `CHK(bank, '0)
        @(posedge i_core_clk);
        i_nrst <= 1'b1;
        op(op_in, 8'h13, 3'h0, 8'h00);
        `CHK(rd, 8'h00)
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    // Hang guard, far above the roughly two hundred cycles the run needs
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        i_nrst = 1'b0;
        pins = '0;
        flags = '0;
        repeat (16) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        #1;
        `CHK(bank, '0)
        t_byte();
        t_reserved();
        t_bits();
        t_flags();
        t_pins();
        t_mid_reset();
        results();
    end
endmodule
